/* File: rtl/enable_reg8.sv */
// One eight-bit read/write enable register with reset to a constant
`timescale 1ns/1ps
`include "irq_enable_regs.svh"
module enable_reg8 (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  output logic [7:0] value_q
);

  // Reset clears every enable so nothing fires before software acts
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      value_q <= 8'h00;
    end else if (wr_en) begin
      value_q <= wdata;
    end
  end

endmodule : enable_reg8

/* File: rtl/event_flag8.sv */
// Eight sticky event flags, each set only when its enable permits
`timescale 1ns/1ps
module event_flag8 (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] event_in,
  input wire logic [7:0] enable,
  input wire logic [7:0] clear,
  output logic [7:0] flag_q
);

  // Gated set; set wins over a clear in the same cycle
  wire logic [7:0] set_w = event_in & enable;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flag_q <= 8'h00;
    end else begin
      flag_q <= (flag_q & ~clear) | set_w;
    end
  end

endmodule : event_flag8

/* File: rtl/irq_enable_pkg.sv */
// Types shared by the event enable block
package irq_enable_pkg;

  // Register bus request
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Raw event strobes of each direction
  typedef struct packed {
    logic frame_sent;
    logic sync_sent;
    logic send_begin;
    logic csma_done;
    logic cca_done;
    logic underflow;
    logic sent_count;
    logic bank_one_sent;
    logic bank_zero_sent;
  } tx_events_t;

  typedef struct packed {
    logic timeout;
    logic level;
    logic frame_received;
    logic length_error;
    logic address_reject;
    logic receive_begin;
    logic preamble_found;
    logic carrier_sense;
    logic agc_done;
  } rx_events_t;

  // Read path state
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_HIT = 2'b01,
    RD_MISS = 2'b11
  } rd_state_t;

endpackage : irq_enable_pkg

/* File: rtl/irq_enable_regs.svh */
// Register offsets, field positions and reset values of the event enable block
`ifndef IRQ_ENABLE_REGS_SVH
`define IRQ_ENABLE_REGS_SVH

// Register addresses
`define TX_EN_ADDR 10'h108
`define RX_EN_ADDR 10'h109

// Reset values
`define TX_EN_RESET 8'h00
`define RX_EN_RESET 8'h00

// Transmit enable fields
`define TX_FRAME_SENT_BIT 7
`define TX_SYNC_SENT_BIT 6
`define TX_BEGIN_BIT 5
`define TX_CHANNEL_DONE_BIT 4
`define TX_UNDERFLOW_BIT 3
`define TX_COUNT_BIT 2
`define TX_BANK_ONE_BIT 1
`define TX_BANK_ZERO_BIT 0

// Receive enable fields
`define RX_TIMEOUT_BIT 7
`define RX_LEVEL_BIT 6
`define RX_FRAME_BIT 5
`define RX_FILTER_BIT 4
`define RX_BEGIN_BIT 3
`define RX_PREAMBLE_BIT 2
`define RX_CARRIER_BIT 1
`define RX_AGC_BIT 0

`endif

/* File: rtl/txrx_irq_source_enables.sv */
// Transmit and receive event enable registers with gated sticky flags
// Behaviour
// - Events request only when their enable permits
// - Enabled event sets its matching flag
// - Both enable registers reset to zero
// - Transmit enable register at 0x108, fixed bits
// - Receive enable register at 0x109, fixed bits
// - Each enable bit: zero off, one on
// - Transmit bit 4 gates CSMA or CCA
// - Receive bit 4 gates length or address
// - Bank one and zero gated separately
`timescale 1ns/1ps
`include "irq_enable_regs.svh"
module txrx_irq_source_enables (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire irq_enable_pkg::tx_events_t tx_events,
  input wire irq_enable_pkg::rx_events_t rx_events,
  input wire logic [7:0] tx_flag_clear,
  input wire logic [7:0] rx_flag_clear,
  output logic [7:0] tx_flags,
  output logic [7:0] rx_flags,
  output logic [7:0] tx_enable,
  output logic [7:0] rx_enable
);

  // Bus request bundled for decoding
  irq_enable_pkg::reg_req_t req_w;
  assign req_w = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Address decode
  wire logic tx_sel_w = (req_w.addr == `TX_EN_ADDR);
  wire logic rx_sel_w = (req_w.addr == `RX_EN_ADDR);
  wire logic tx_wr_w = req_w.wr && tx_sel_w;
  wire logic rx_wr_w = req_w.wr && rx_sel_w;

  // Enable register contents
  logic [7:0] tx_en_w;
  logic [7:0] rx_en_w;

  enable_reg8 u_tx_en (
    .clock(clock),
    .rst_n(rst_n),
    .wr_en(tx_wr_w),
    .wdata(req_w.wdata),
    .value_q(tx_en_w)
  );

  enable_reg8 u_rx_en (
    .clock(clock),
    .rst_n(rst_n),
    .wr_en(rx_wr_w),
    .wdata(req_w.wdata),
    .value_q(rx_en_w)
  );

  // Transmit event vector in register bit order
  logic [7:0] tx_vec_w;
  always_comb begin
    tx_vec_w = 8'h00;
    tx_vec_w[`TX_FRAME_SENT_BIT] = tx_events.frame_sent;
    tx_vec_w[`TX_SYNC_SENT_BIT] = tx_events.sync_sent;
    tx_vec_w[`TX_BEGIN_BIT] = tx_events.send_begin;
    // Two completions share one enable and one flag
    tx_vec_w[`TX_CHANNEL_DONE_BIT] = tx_events.csma_done | tx_events.cca_done;
    tx_vec_w[`TX_UNDERFLOW_BIT] = tx_events.underflow;
    tx_vec_w[`TX_COUNT_BIT] = tx_events.sent_count;
    tx_vec_w[`TX_BANK_ONE_BIT] = tx_events.bank_one_sent;
    tx_vec_w[`TX_BANK_ZERO_BIT] = tx_events.bank_zero_sent;
  end

  // Receive event vector in register bit order
  logic [7:0] rx_vec_w;
  always_comb begin
    rx_vec_w = 8'h00;
    rx_vec_w[`RX_TIMEOUT_BIT] = rx_events.timeout;
    rx_vec_w[`RX_LEVEL_BIT] = rx_events.level;
    rx_vec_w[`RX_FRAME_BIT] = rx_events.frame_received;
    // Either frame check failure raises the shared request
    rx_vec_w[`RX_FILTER_BIT] = rx_events.length_error | rx_events.address_reject;
    rx_vec_w[`RX_BEGIN_BIT] = rx_events.receive_begin;
    rx_vec_w[`RX_PREAMBLE_BIT] = rx_events.preamble_found;
    rx_vec_w[`RX_CARRIER_BIT] = rx_events.carrier_sense;
    rx_vec_w[`RX_AGC_BIT] = rx_events.agc_done;
  end

  // Sticky flags; a zero enable bit blocks the set entirely
  logic [7:0] tx_flag_w;
  logic [7:0] rx_flag_w;

  event_flag8 u_tx_flags (
    .clock(clock),
    .rst_n(rst_n),
    .event_in(tx_vec_w),
    .enable(tx_en_w),
    .clear(tx_flag_clear),
    .flag_q(tx_flag_w)
  );

  event_flag8 u_rx_flags (
    .clock(clock),
    .rst_n(rst_n),
    .event_in(rx_vec_w),
    .enable(rx_en_w),
    .clear(rx_flag_clear),
    .flag_q(rx_flag_w)
  );

  // Flags and enables leave straight from flip-flops
  assign tx_flags = tx_flag_w;
  assign rx_flags = rx_flag_w;
  assign tx_enable = tx_en_w;
  assign rx_enable = rx_en_w;

  // Read data mux; unmapped addresses read zero
  wire logic [7:0] rd_mux_w = tx_sel_w ? tx_en_w :
                              rx_sel_w ? rx_en_w : 8'h00;

  // Read data registered one cycle after the strobe, only for that cycle
  logic [7:0] rdata_q;
  irq_enable_pkg::rd_state_t rd_state_q;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      rd_state_q <= irq_enable_pkg::RD_IDLE;
    end else if (req_w.rd) begin
      rdata_q <= rd_mux_w;
      rd_state_q <= (tx_sel_w || rx_sel_w) ? irq_enable_pkg::RD_HIT : irq_enable_pkg::RD_MISS;
    end else begin
      rdata_q <= 8'h00;
      rd_state_q <= irq_enable_pkg::RD_IDLE;
    end
  end
  assign reg_rdata = rdata_q;

  // Previous-cycle copies for assertions
  logic [7:0] tx_en_prev_q;
  always_ff @(posedge clock) begin
    tx_en_prev_q <= tx_en_w;
  end

  // A write to the transmit register appears next cycle
  a_tx_write_lands: assert property (@(posedge clock) disable iff (!rst_n)
    tx_wr_w |=> tx_en_w == $past(req_w.wdata))
    else $error("transmit enable write not stored");

  // A write to the receive register appears next cycle
  a_rx_write_lands: assert property (@(posedge clock) disable iff (!rst_n)
    rx_wr_w |=> rx_en_w == $past(req_w.wdata))
    else $error("receive enable write not stored");

  // Transmit enables hold without a write
  a_enable_holds: assert property (@(posedge clock) disable iff (!rst_n)
    !req_w.wr |=> tx_en_w == tx_en_prev_q)
    else $error("transmit enable changed without write");

  // Read returns register value one cycle later
  a_read_back: assert property (@(posedge clock) disable iff (!rst_n)
    (req_w.rd && rx_sel_w) |=> reg_rdata == rx_en_w)
    else $error("receive enable read back mismatch");

  // Reset clears both enables
  a_reset_clear: assert property (@(posedge clock)
    !rst_n |=> (tx_en_w == 8'h00 && rx_en_w == 8'h00))
    else $error("enables not cleared by reset");

  // Disabled source never sets a fresh flag
  a_gate_blocks: assert property (@(posedge clock) disable iff (!rst_n)
    (!tx_en_w[`TX_UNDERFLOW_BIT] && !tx_flag_w[`TX_UNDERFLOW_BIT])
      |=> !tx_flag_w[`TX_UNDERFLOW_BIT])
    else $error("underflow flag set while disabled");

  // Enabled event sets flag
  a_flag_sets: assert property (@(posedge clock) disable iff (!rst_n)
    (rx_en_w[`RX_AGC_BIT] && rx_events.agc_done) |=> rx_flag_w[`RX_AGC_BIT])
    else $error("agc flag not set");

  // Shared channel flag reacts to CCA alone
  a_cca_shared: assert property (@(posedge clock) disable iff (!rst_n)
    (tx_en_w[`TX_CHANNEL_DONE_BIT] && tx_events.cca_done) |=> tx_flag_w[`TX_CHANNEL_DONE_BIT])
    else $error("cca completion did not set shared flag");

  // Shared filter flag reacts to address reject alone
  a_filter_shared: assert property (@(posedge clock) disable iff (!rst_n)
    (rx_en_w[`RX_FILTER_BIT] && rx_events.address_reject) |=> rx_flag_w[`RX_FILTER_BIT])
    else $error("address reject did not set shared flag");

  // Bank one event does not touch bank zero flag
  a_bank_split: assert property (@(posedge clock) disable iff (!rst_n)
    (tx_events.bank_one_sent && !tx_events.bank_zero_sent
      && !tx_flag_w[`TX_BANK_ZERO_BIT]) |=> !tx_flag_w[`TX_BANK_ZERO_BIT])
    else $error("bank zero flag set by bank one");

  // Receive enables hold without a write
  a_rx_holds: assert property (@(posedge clock) disable iff (!rst_n)
    !req_w.wr |=> $stable(rx_en_w))
    else $error("receive enable changed without write");

  // An unmapped read answers zero
  a_miss_reads_zero: assert property (@(posedge clock) disable iff (!rst_n)
    (rd_state_q == irq_enable_pkg::RD_MISS) |-> reg_rdata == 8'h00)
    else $error("unmapped read returned data");

  // Read data stand only in the cycle after the strobe
  a_idle_rdata_zero: assert property (@(posedge clock) disable iff (!rst_n)
    (rd_state_q == irq_enable_pkg::RD_IDLE) |-> reg_rdata == 8'h00)
    else $error("read data present without a read");

  // Receive level enable bit at one with a level event sets its flag one cycle later
  a_bit_encoding: assert property (@(posedge clock) disable iff (!rst_n)
    (rx_en_w[`RX_LEVEL_BIT] && rx_events.level) |=> rx_flag_w[`RX_LEVEL_BIT])
    else $error("level flag not set while enabled");

endmodule : txrx_irq_source_enables

/* File: verif/txrx_irq_source_enables_tb_top.sv */
// Self-checking bench for the transmit and receive event enable block
`timescale 1ns/1ps
`include "irq_enable_regs.svh"
module txrx_irq_source_enables_tb_top;
  // Expected result note: which output to look at and what it should hold
  typedef struct packed {
    logic [2:0] src;
    logic [7:0] val;
  } note_t;
  logic clock = 1'b0; // 100 MHz bench clock
  logic rst_n = 1'b0; // Held low for the first six edges
  logic [9:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  irq_enable_pkg::tx_events_t tx_events = '0;
  irq_enable_pkg::rx_events_t rx_events = '0;
  logic [7:0] tx_flag_clear = '0;
  logic [7:0] rx_flag_clear = '0;
  logic [7:0] tx_flags;
  logic [7:0] rx_flags;
  logic [7:0] tx_enable;
  logic [7:0] rx_enable;
  logic rd_taken = 1'b0; // Read data stand in this cycle
  logic look = 1'b0; // A settled output is due for comparison
  note_t notes[$]; // Oldest expectation first
  int err_total = 0;
  int n_tests = 0;
  logic [31:0] s = 32'hB5AB; // Random state
  logic [31:0] t;

  txrx_irq_source_enables txrx_irq_source_enables_i (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_events(tx_events),
    .rx_events(rx_events), .tx_flag_clear(tx_flag_clear), .rx_flag_clear(rx_flag_clear),
    .tx_flags(tx_flags), .rx_flags(rx_flags), .tx_enable(tx_enable), .rx_enable(rx_enable)
  );

  // Clock toggles every half period
  always #5 clock = ~clock;

  // Galois-free shift register; cheap and repeatable from one seed
  function logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  // Flag positions expected for a transmit event pattern
  function logic [7:0] tx_map(input irq_enable_pkg::tx_events_t e);
    return {e.frame_sent, e.sync_sent, e.send_begin, e.csma_done | e.cca_done,
            e.underflow, e.sent_count, e.bank_one_sent, e.bank_zero_sent};
  endfunction : tx_map

  // Flag positions expected for a receive event pattern
  function logic [7:0] rx_map(input irq_enable_pkg::rx_events_t e);
    return {e.timeout, e.level, e.frame_received, e.length_error | e.address_reject,
            e.receive_begin, e.preamble_found, e.carrier_sense, e.agc_done};
  endfunction : rx_map

  // One cycle of every input; notes an expectation when a result is due
  task cyc(input logic w, input logic r, input logic [9:0] a, input logic [7:0] d,
           input logic [17:0] ev, input logic [15:0] cl, input logic [2:0] src,
           input logic [7:0] x);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    {tx_events, rx_events} <= ev;
    {tx_flag_clear, rx_flag_clear} <= cl;
    look <= !r && (src != 3'h0);
    if (r || src != 3'h0) begin
      notes.push_back({src, x});
    end
    @(posedge clock);
  endtask : cyc

  // Compare one value and count it
  task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Print the counts and the verdict, then stop
  task conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  // Read data are only valid the cycle after the strobe edge
  always @(posedge clock) begin
    rd_taken <= reg_rd;
  end

  // Watcher: takes the oldest note whenever a result is settled
  // A read answer and an output look can fall in one cycle; the read note is older
  always @(negedge clock) begin
    note_t n;
    for (int k = 0; k < 2; k++) begin
      if (((k == 0) ? rd_taken : look) && notes.size() > 0) begin
        n = notes.pop_front();
        case (n.src)
          3'h0: check("reg_rdata", reg_rdata, n.val);
          3'h1: check("tx_flags", tx_flags, n.val);
          3'h2: check("rx_flags", rx_flags, n.val);
          3'h4: check("rx_enable", rx_enable, n.val);
          default: check("tx_enable", tx_enable, n.val);
        endcase
      end
    end
  end

  // Watchdog far beyond the roughly two hundred cycles the sequence needs
  initial begin
    repeat (3000) @(posedge clock);
    err_total++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    cyc(0, 1, `TX_EN_ADDR, 8'h00, '0, '0, 2'h0, `TX_EN_RESET);
    cyc(0, 1, `RX_EN_ADDR, 8'h00, '0, '0, 2'h0, `RX_EN_RESET);
    cyc(0, 1, 10'h10A, 8'h00, '0, '0, 2'h0, 8'h00);
    // Back-to-back writes and reads with random contents
    for (int i = 0; i < 8; i++) begin
      s = lfsr(s);
      cyc(1, 0, `TX_EN_ADDR, s[7:0], '0, '0, 2'h0, 8'h00);
      cyc(1, 0, `RX_EN_ADDR, s[15:8], '0, '0, 2'h0, 8'h00);
      cyc(0, 1, `TX_EN_ADDR, 8'h00, '0, '0, 2'h0, s[7:0]);
      cyc(0, 1, `RX_EN_ADDR, 8'h00, '0, '0, 2'h0, s[15:8]);
      cyc(0, 0, 10'h000, 8'h00, '0, '0, 3'h3, s[7:0]);
      cyc(0, 0, 10'h000, 8'h00, '0, '0, 3'h4, s[15:8]);
    end
    // A write to an unmapped place must leave both registers alone
    cyc(1, 0, 10'h10A, 8'hFF, '0, '0, 2'h0, 8'h00);
    cyc(0, 1, `TX_EN_ADDR, 8'h00, '0, '0, 2'h0, s[7:0]);
    cyc(0, 1, `RX_EN_ADDR, 8'h00, '0, '0, 2'h0, s[15:8]);
    // Random enables against random event bursts, then clear
    for (int i = 0; i < 16; i++) begin
      s = lfsr(s);
      t = lfsr(s);
      cyc(1, 0, `TX_EN_ADDR, s[7:0], '0, '0, 2'h0, 8'h00);
      cyc(1, 0, `RX_EN_ADDR, s[15:8], '0, '0, 2'h0, 8'h00);
      cyc(0, 0, 10'h000, 8'h00, t[17:0], '0, 2'h0, 8'h00);
      cyc(0, 0, 10'h000, 8'h00, '0, '0, 2'h1, tx_map(t[17:9]) & s[7:0]);
      cyc(0, 0, 10'h000, 8'h00, '0, '0, 2'h2, rx_map(t[8:0]) & s[15:8]);
      cyc(0, 0, 10'h000, 8'h00, '0, 16'hFFFF, 2'h0, 8'h00);
      cyc(0, 0, 10'h000, 8'h00, '0, '0, 2'h1, 8'h00);
      cyc(0, 0, 10'h000, 8'h00, '0, '0, 2'h2, 8'h00);
    end
    // Second reset in mid-run returns both registers to zero
    cyc(0, 0, 10'h000, 8'h00, '0, '0, 2'h0, 8'h00);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    cyc(0, 1, `TX_EN_ADDR, 8'h00, '0, '0, 2'h0, `TX_EN_RESET);
    cyc(0, 1, `RX_EN_ADDR, 8'h00, '0, '0, 2'h0, `RX_EN_RESET);
    cyc(0, 0, 10'h000, 8'h00, '0, '0, 2'h0, 8'h00);
    @(posedge clock);
    conclude();
  end
endmodule : txrx_irq_source_enables_tb_top
